// [dv/b2c_buck2_ctrl_bench.sv]
`include "b2c_params.svh"
`timescale 1ns/1ps
`default_nettype none

module b2c_buck2_ctrl_bench
    import b2c_pkg::*;
;
    localparam logic [15:0] A_HWC = `B2C_ADDR_FAULT_HWC;
    localparam logic [15:0] A_ON  = `B2C_ADDR_ON_CFG;
    localparam logic [15:0] A_ST  = `B2C_ADDR_IRQ_STAT;
    localparam logic [15:0] A_CL  = `B2C_ADDR_IRQ_CLR;
    localparam logic [15:0] A_EN  = `B2C_ADDR_IRQ_EN;

    logic        clk = 1'b0;
    logic        rst_n, wr_strobe, rd_strobe, brownout;
    logic        hw_ctrl1, hw_ctrl2, hw_en1, hw_en2, slot_pulse, freq_4mhz, nvm_load;
    logic [15:0] addr, wdata, rdata;
    logic [11:0] load_ma, hc_ma;
    logic [6:0]  sleep_code, vcode;
    logic [4:0]  nvm_hi;
    logic [2:0]  slot_num;
    logic [1:0]  mode;
    logic        uv_fault, hc_trip, enable, hc_en, rst_req, irq;
    int          miscompares = 0;
    int          check_count = 0;
    logic [6:0]  vin  [7] = '{7'h00, 7'h08, 7'h09, 7'h48, 7'h67, 7'h68, 7'h7f};
    logic [6:0]  vout [7] = '{7'h08, 7'h08, 7'h09, 7'h48, 7'h67, 7'h68, 7'h68};
    logic [1:0]  acts [4] = '{2'h0, 2'h3, 2'h2, 2'h1};

    always #50 clk = ~clk;

    b2c_buck2_ctrl b2c_buck2_ctrl_i (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr_strobe), .i_rd(rd_strobe), .o_rdata(rdata),
        .i_undervoltage_fault(uv_fault), .i_high_current_trip(hc_trip),
        .i_hw_ctrl1(hw_ctrl1), .i_hw_ctrl2(hw_ctrl2), .i_hw_enable1(hw_en1),
        .i_hw_enable2(hw_en2), .i_timeslot_pulse(slot_pulse), .i_timeslot_num(slot_num),
        .i_sleep_voltage_code(sleep_code), .i_freq_4mhz(freq_4mhz), .i_nvm_load(nvm_load),
        .i_nvm_voltage_hi(nvm_hi), .o_enable(enable), .o_mode(mode), .o_voltage_code(vcode),
        .o_hc_detect_en(hc_en), .o_hc_threshold_ma(hc_ma), .o_device_reset_req(rst_req),
        .o_irq(irq)
    );

    b2c_stage_model b2c_stage_model_i (
        .i_core_clk(clk), .i_hc_threshold_ma(hc_ma), .i_load_ma(load_ma),
        .i_brownout(brownout), .o_undervoltage_fault(uv_fault), .o_high_current_trip(hc_trip)
    );

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk) begin
            addr <= a;
            wdata <= d;
            wr_strobe <= 1'b1;
        end
        @(posedge clk) wr_strobe <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk) begin
            addr <= a;
            rd_strobe <= 1'b1;
        end
        @(posedge clk) rd_strobe <= 1'b0;
        #1 chk(rdata, exp);
    endtask

    task automatic pulse(input logic [2:0] n);
        @(posedge clk) begin
            slot_pulse <= 1'b1;
            slot_num <= n;
        end
        @(posedge clk) slot_pulse <= 1'b0;
        tick(1);
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (check_count > 0 && miscompares == 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        int seen;
        {rst_n, wr_strobe, rd_strobe, brownout, hw_ctrl1, hw_ctrl2, hw_en1, hw_en2} = '0;
        {slot_pulse, freq_4mhz, nvm_load, addr, wdata, load_ma, nvm_hi, slot_num} = '0;
        sleep_code = 7'h30;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        tick(1);
        chk(mode, B2C_MODE_AUTO);
        chk(vcode, 16'h0008);
        chk(hc_ma, 16'h00fa);
        chk({hc_en, enable, irq, rst_req}, 16'h0000);
        rdc(A_HWC, 16'h0300);
        rdc(A_ON, 16'h0100);
        rdc(16'h4063, 16'h0000);
        wr(A_HWC, 16'hffff);
        rdc(A_HWC, `B2C_MASK_FAULT_HWC);
        wr(A_CL, 16'h0003);
        rdc(A_CL, 16'h0000);
        for (int t = 0; t < 8; t++) begin
            wr(A_HWC, 16'h0301 | 16'(t << 4));
            tick(1);
            chk(hc_ma, 16'((t + 1) * 250));
            chk(hc_en, 16'h0001);
        end
        for (int i = 0; i < 7; i++) begin
            wr(A_ON, 16'h0100 | 16'(vin[i]));
            tick(1);
            chk(vcode, vout[i]);
        end
        @(posedge clk) freq_4mhz <= 1'b1;
        wr(A_ON, 16'h0160);
        tick(1);
        chk(vcode, 16'h0048);
        @(posedge clk) freq_4mhz <= 1'b0;
        tick(1);
        chk(vcode, 16'h0060);
        wr(A_ON, 16'h6020);
        pulse(3'h2);
        chk(enable, 16'h0000);
        pulse(3'h3);
        chk(enable, 16'h0001);
        for (int m = 0; m < 4; m++) begin
            wr(A_ON, 16'h6020 | 16'(m << 8));
            tick(1);
            chk(mode, 16'(m));
        end
        // Hardware control: source two selected while only input one is raised
        wr(A_HWC, 16'h1600);
        @(posedge clk) hw_ctrl1 <= 1'b1;
        tick(5);
        chk(vcode, 16'h0020);
        wr(A_HWC, 16'h1e00);
        tick(1);
        chk({mode, vcode}, {B2C_MODE_LDO, 7'h30});
        wr(A_HWC, 16'h0a00);
        tick(1);
        chk(vcode, 16'h0020);
        wr(A_HWC, 16'h0900);
        tick(1);
        chk(enable, 16'h0000);
        @(posedge clk) hw_ctrl1 <= 1'b0;
        tick(5);
        chk({enable, mode}, {1'b1, B2C_MODE_HYST});
        wr(A_EN, 16'h0003);
        for (int k = 0; k < 4; k++) begin
            wr(A_HWC, 16'(acts[k]) << 14);
            @(posedge clk) brownout <= 1'b1;
            seen = 0;
            for (int c = 0; c < 8; c++) begin
                tick(1);
                if (rst_req === 1'b1)
                    seen++;
            end
            chk(16'(seen), 16'(acts[k] == 2'h2));
            chk(irq, 16'h0001);
            rdc(A_ST, 16'h0001);
            if (acts[k] != 2'h2)
                chk(enable, 16'(acts[k] != 2'h1));
            @(posedge clk) brownout <= 1'b0;
            wr(A_CL, 16'h0001);
            tick(1);
            chk(irq, 16'h0000);
        end
        wr(A_HWC, 16'h0000);
        @(posedge clk) load_ma <= 12'd600;
        tick(5);
        rdc(A_ST, 16'h0000);
        @(posedge clk) load_ma <= 12'd0;
        wr(A_HWC, 16'h0011);
        @(posedge clk) load_ma <= 12'd600;
        tick(5);
        rdc(A_ST, 16'h0002);
        chk(irq, 16'h0001);
        wr(A_EN, 16'h0001);
        tick(1);
        chk(irq, 16'h0000);
        rdc(A_EN, 16'h0001);
        wr(A_CL, 16'h0002);
        rdc(A_ST, 16'h0000);
        wr(A_ON, 16'h6323);
        @(posedge clk) begin
            nvm_load <= 1'b1;
            nvm_hi <= 5'h1a;
        end
        @(posedge clk) nvm_load <= 1'b0;
        rdc(A_ON, 16'h6368);
        chk(vcode, 16'h0068);
        wr(A_ON, 16'hc100);
        @(posedge clk) hw_en1 <= 1'b1;
        tick(5);
        chk(enable, 16'h0001);
        wr(A_ON, 16'he100);
        tick(2);
        chk(enable, 16'h0000);
        @(posedge clk) hw_en2 <= 1'b1;
        tick(5);
        chk(enable, 16'h0001);
        // Input two alone must govern source two and either, but not source one
        wr(A_HWC, 16'h1600);
        @(posedge clk) hw_ctrl2 <= 1'b1;
        tick(5);
        chk({mode, vcode}, {B2C_MODE_LDO, 7'h30});
        wr(A_HWC, 16'h0e00);
        tick(1);
        chk({mode, vcode}, {B2C_MODE_AUTO, 7'h08});
        wr(A_HWC, 16'h1e00);
        tick(1);
        chk(vcode, 16'h0030);
        end_sim();
    end
endmodule // b2c_buck2_ctrl_bench

`default_nettype wire

// [dv/b2c_stage_model.sv]
`timescale 1ns/1ps
`default_nettype none

module b2c_stage_model (
    input  wire logic        i_core_clk,
    input  wire logic [11:0] i_hc_threshold_ma,
    input  wire logic [11:0] i_load_ma,
    input  wire logic        i_brownout,
    output var  logic        o_undervoltage_fault,
    output var  logic        o_high_current_trip
);
    logic uv_reg   = 1'b0;
    logic trip_reg = 1'b0;

    // Raw comparator runs even with detection off, so the block must do the gating
    always @(posedge i_core_clk) begin
        trip_reg <= (i_load_ma > i_hc_threshold_ma);
        uv_reg   <= i_brownout;
    end

    assign o_undervoltage_fault = uv_reg;
    assign o_high_current_trip  = trip_reg;
endmodule // b2c_stage_model

`default_nettype wire

// [logic/b2c_buck2_ctrl.sv]
// Overview of operation
// - Undervoltage action: 00 ignore, 01 stop this converter, 10 device reset, 11 reserved.
// - Every undervoltage fault sets its interrupt flag, whatever the action field says; the interrupt line needs enable bit 0.
// - Hardware control source: 00 none, 01 input one, 10 input two, 11 either.
// - Under hardware control, voltage pick 0 uses on code, 1 uses sleep code.
// - Hardware mode: 00 forced, 01 disabled, 10 linear, 11 hysteretic; resets 11.
// - High current threshold is 250 mA per step, 250 to 2000 mA.
// - High current detector works only with enable bit 0 set; resets off.
// - Start slot: 000 never, 001-101 timeslot one-five, 110/111 hardware enable.
// - On mode: 00 forced, 01 auto, 10 linear, 11 hysteretic; resets 01.
// - Voltage code steps 12.5 mV; 00h-08h give 0.6 V, 68h-7Fh 1.8 V.
// - At 4 MHz switching the selected voltage code never exceeds 48h.
// - Only code bits 6:2 load from configuration memory; bits 1:0 register only.
`include "b2c_params.svh"
`timescale 1ns/1ps
`default_nettype none

module b2c_buck2_ctrl
    import b2c_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    input  wire logic [15:0] i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output var  logic [15:0] o_rdata,
    input  wire logic        i_undervoltage_fault,
    input  wire logic        i_high_current_trip,
    input  wire logic        i_hw_ctrl1,
    input  wire logic        i_hw_ctrl2,
    input  wire logic        i_hw_enable1,
    input  wire logic        i_hw_enable2,
    input  wire logic        i_timeslot_pulse,
    input  wire logic [2:0]  i_timeslot_num,
    input  wire logic [6:0]  i_sleep_voltage_code,
    input  wire logic        i_freq_4mhz,
    input  wire logic        i_nvm_load,
    input  wire logic [4:0]  i_nvm_voltage_hi,
    output var  logic        o_enable,
    output var  logic [1:0]  o_mode,
    output var  logic [6:0]  o_voltage_code,
    output var  logic        o_hc_detect_en,
    output var  logic [11:0] o_hc_threshold_ma,
    output var  logic        o_device_reset_req,
    output var  logic        o_irq
);

    logic [15:0]  fault_hwc_reg;
    logic [15:0]  on_cfg_reg;
    logic [1:0]   irq_stat_reg;
    logic [1:0]   irq_stat_next;
    logic [1:0]   irq_en_reg;
    logic [1:0]   irq_clr;
    logic [5:0]   pins_sync;
    logic         uv_prev_reg;
    logic         hc_prev_reg;
    logic         uv_event;
    logic         hc_event;
    b2c_state_e   state_reg;
    b2c_state_e   state_next;
    b2c_uv_act_e  uv_act;
    b2c_hwsrc_e   hw_src;
    logic [1:0]   hwc_mode;
    logic [1:0]   on_mode;
    logic [2:0]   slot;
    logic [2:0]   hc_thr;
    logic         hc_en;
    logic         hw_active;
    logic         slot_start;
    logic         slot_hold;
    logic [6:0]   vsel_raw;
    logic [6:0]   vsel_next;
    logic [1:0]   mode_next;

    // Pin order: uv, hc, ctrl1, ctrl2, en1, en2
    b2c_sync #(
        .WIDTH (6)
    ) u_pin_sync (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_async    ({i_hw_enable2, i_hw_enable1, i_hw_ctrl2, i_hw_ctrl1,
                      i_high_current_trip, i_undervoltage_fault}),
        .o_sync     (pins_sync)
    );

    assign uv_act   = b2c_uv_act_e'(fault_hwc_reg[`B2C_UV_ACT_LSB +: 2]);
    assign hw_src   = b2c_hwsrc_e'(fault_hwc_reg[`B2C_HWC_SRC_LSB +: 2]);
    assign hwc_mode = fault_hwc_reg[`B2C_HWC_MODE_LSB +: 2];
    assign hc_thr   = fault_hwc_reg[`B2C_HC_THR_LSB +: 3];
    assign hc_en    = fault_hwc_reg[`B2C_HC_EN_BIT];
    assign slot     = on_cfg_reg[`B2C_SLOT_LSB +: 3];
    assign on_mode  = on_cfg_reg[`B2C_ON_MODE_LSB +: 2];
    assign irq_clr  = (i_wr && i_addr == `B2C_ADDR_IRQ_CLR) ? i_wdata[1:0] : 2'h0;

    // Register writes
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            fault_hwc_reg <= `B2C_RST_FAULT_HWC;
        end else if (i_wr && i_addr == `B2C_ADDR_FAULT_HWC) begin
            fault_hwc_reg <= i_wdata & `B2C_MASK_FAULT_HWC;
        end
    end

    // A configuration load carries only the coarse code bits and zeroes the fine ones
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            on_cfg_reg <= `B2C_RST_ON_CFG;
        end else if (i_nvm_load) begin
            on_cfg_reg[6:0] <= {i_nvm_voltage_hi, 2'h0};
        end else if (i_wr && i_addr == `B2C_ADDR_ON_CFG) begin
            on_cfg_reg <= i_wdata & `B2C_MASK_ON_CFG;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            irq_en_reg <= 2'h0;
        end else if (i_wr && i_addr == `B2C_ADDR_IRQ_EN) begin
            irq_en_reg <= i_wdata[1:0];
        end
    end

    // Read data stand one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            case (i_addr)
                `B2C_ADDR_FAULT_HWC: o_rdata <= fault_hwc_reg;
                `B2C_ADDR_ON_CFG:    o_rdata <= on_cfg_reg;
                `B2C_ADDR_IRQ_STAT:  o_rdata <= {14'h0000, irq_stat_reg};
                `B2C_ADDR_IRQ_EN:    o_rdata <= {14'h0000, irq_en_reg};
                default:             o_rdata <= 16'h0000;
            endcase
        end else begin
            o_rdata <= 16'h0000;
        end
    end

    // Events from the synchronised fault pins
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            uv_prev_reg <= 1'b0;
            hc_prev_reg <= 1'b0;
        end else begin
            uv_prev_reg <= pins_sync[0];
            hc_prev_reg <= pins_sync[1];
        end
    end

    assign uv_event = pins_sync[0] && !uv_prev_reg;
    assign hc_event = pins_sync[1] && !hc_prev_reg && hc_en;

    // Set beats clear so an event in the clearing cycle survives
    always_comb begin
        irq_stat_next = irq_stat_reg & ~irq_clr;
        irq_stat_next[`B2C_IRQ_UV_BIT] = irq_stat_next[`B2C_IRQ_UV_BIT] | uv_event;
        irq_stat_next[`B2C_IRQ_HC_BIT] = irq_stat_next[`B2C_IRQ_HC_BIT] | hc_event;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            irq_stat_reg <= 2'h0;
            o_irq        <= 1'b0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            o_irq        <= |(irq_stat_next & irq_en_reg);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_device_reset_req <= 1'b0;
        end else begin
            o_device_reset_req <= uv_event && uv_act == B2C_UV_RESET;
        end
    end

    // Hardware control selection
    always_comb begin
        case (hw_src)
            B2C_HWSRC_IN1: hw_active = pins_sync[2];
            B2C_HWSRC_IN2: hw_active = pins_sync[3];
            B2C_HWSRC_ANY: hw_active = pins_sync[2] | pins_sync[3];
            default:       hw_active = 1'b0;
        endcase
    end

    // Start-up slot decode
    always_comb begin
        slot_start = 1'b0;
        slot_hold  = 1'b1;
        case (slot)
            3'h0: slot_hold = 1'b0;
            3'h6: begin
                slot_start = pins_sync[4];
                slot_hold  = pins_sync[4];
            end
            3'h7: begin
                slot_start = pins_sync[5];
                slot_hold  = pins_sync[5];
            end
            default: slot_start = i_timeslot_pulse && i_timeslot_num == slot;
        endcase
    end

    // Converter state; a tripped converter waits for software to clear the fault flag
    always_comb begin
        case (state_reg)
            B2C_ST_OFF: state_next = slot_start ? B2C_ST_ON : B2C_ST_OFF;
            B2C_ST_ON: begin
                if (uv_event && uv_act == B2C_UV_SHUTDOWN) begin
                    state_next = B2C_ST_TRIPPED;
                end else if (!slot_hold) begin
                    state_next = B2C_ST_OFF;
                end else begin
                    state_next = B2C_ST_ON;
                end
            end
            B2C_ST_TRIPPED: begin
                state_next = irq_clr[`B2C_IRQ_UV_BIT] ? B2C_ST_OFF : B2C_ST_TRIPPED;
            end
            default: state_next = B2C_ST_OFF;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            state_reg <= B2C_ST_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // Operating point
    always_comb begin
        if (hw_active) begin
            vsel_raw  = fault_hwc_reg[`B2C_HWC_VPICK_BIT] ? i_sleep_voltage_code
                                                          : on_cfg_reg[6:0];
            mode_next = hwc_mode;
        end else begin
            vsel_raw  = on_cfg_reg[6:0];
            mode_next = on_mode;
        end
        // Codes outside the linear span give the end voltages
        if (vsel_raw < `B2C_VSEL_FLOOR) begin
            vsel_next = `B2C_VSEL_FLOOR;
        end else if (vsel_raw > `B2C_VSEL_CEIL) begin
            vsel_next = `B2C_VSEL_CEIL;
        end else begin
            vsel_next = vsel_raw;
        end
        // Cap in hardware too, since software may leave a high code before a rate change
        if (i_freq_4mhz && vsel_next > `B2C_VSEL_MAX_4MHZ) begin
            vsel_next = `B2C_VSEL_MAX_4MHZ;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_voltage_code <= `B2C_VSEL_FLOOR;
            o_mode         <= B2C_MODE_AUTO;
            o_enable       <= 1'b0;
        end else begin
            o_voltage_code <= vsel_next;
            o_mode         <= mode_next;
            o_enable       <= state_next == B2C_ST_ON &&
                              !(hw_active && hwc_mode == B2C_HWC_MODE_OFF);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_hc_detect_en    <= 1'b0;
            o_hc_threshold_ma <= `B2C_HC_STEP_MA;
        end else begin
            o_hc_detect_en    <= hc_en;
            o_hc_threshold_ma <= ({9'h000, hc_thr} + 12'h001) * `B2C_HC_STEP_MA;
        end
    end

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    AST_UV_ALWAYS_FLAGS: assert property (
        uv_event |=> irq_stat_reg[`B2C_IRQ_UV_BIT])
        else $error("undervoltage event did not set its flag");
    AST_UV_SHUTDOWN: assert property (
        (uv_event && uv_act == B2C_UV_SHUTDOWN && state_reg == B2C_ST_ON)
            |=> state_reg == B2C_ST_TRIPPED && !o_enable)
        else $error("undervoltage shutdown not taken");
    AST_UV_RESET_PULSE: assert property (
        (uv_event && uv_act == B2C_UV_RESET) |=> o_device_reset_req ##1 !o_device_reset_req)
        else $error("device reset request not a single pulse");
    AST_UV_NO_RESET: assert property (
        !(uv_event && uv_act == B2C_UV_RESET) |=> !o_device_reset_req)
        else $error("device reset request without cause");
    AST_HW_VOLT_PICK: assert property (
        (hw_active && fault_hwc_reg[`B2C_HWC_VPICK_BIT] && !i_freq_4mhz &&
         i_sleep_voltage_code inside {[7'h08:7'h48]})
            |=> o_voltage_code == $past(i_sleep_voltage_code))
        else $error("hardware control did not pick the sleep code");
    AST_HW_MODE: assert property (
        hw_active |=> o_mode == $past(hwc_mode))
        else $error("hardware control mode not applied");
    AST_ON_MODE: assert property (
        !hw_active |=> o_mode == $past(on_mode))
        else $error("on mode not applied");
    AST_HC_THRESHOLD: assert property (
        ##1 o_hc_threshold_ma == 12'(($past(hc_thr) + 4'h1) * 12'h0fa))
        else $error("high current threshold wrong");
    AST_HC_GATED: assert property (
        (!hc_en && !irq_stat_reg[`B2C_IRQ_HC_BIT]) |=> !irq_stat_reg[`B2C_IRQ_HC_BIT])
        else $error("disabled detector raised a flag");
    AST_CAP_4MHZ: assert property (
        $past(i_freq_4mhz) |-> o_voltage_code <= 7'h48)
        else $error("voltage code above limit at 4 MHz");
    AST_CODE_SPAN: assert property (
        o_voltage_code >= 7'h08 && o_voltage_code <= 7'h68)
        else $error("voltage code outside its span");
    AST_NVM_LOAD: assert property (
        i_nvm_load |=> on_cfg_reg[6:0] == {$past(i_nvm_voltage_hi), 2'h0})
        else $error("configuration load wrong");
    AST_SLOT_NEVER: assert property (
        (slot == 3'h0 && state_reg == B2C_ST_OFF && !i_nvm_load &&
         !(i_wr && i_addr == `B2C_ADDR_ON_CFG)) |=> (state_reg == B2C_ST_OFF) [*2])
        else $error("converter started with slot code zero");

    COV_TRIP:  cover property (state_reg == B2C_ST_ON ##1 state_reg == B2C_ST_TRIPPED);
    COV_RESET: cover property (o_device_reset_req);
    COV_HWC:   cover property (hw_active && o_enable);
    COV_IRQ:   cover property (uv_event && irq_clr[`B2C_IRQ_UV_BIT]);

endmodule // b2c_buck2_ctrl

`default_nettype wire

// [logic/b2c_params.svh]
`ifndef B2C_PARAMS_SVH
`define B2C_PARAMS_SVH

// Register addresses
`define B2C_ADDR_FAULT_HWC   16'h405c
`define B2C_ADDR_ON_CFG      16'h405d
`define B2C_ADDR_IRQ_STAT    16'h4060
`define B2C_ADDR_IRQ_CLR     16'h4061
`define B2C_ADDR_IRQ_EN      16'h4062

// Reset values and writable-bit masks
`define B2C_RST_FAULT_HWC    16'h0300
`define B2C_RST_ON_CFG       16'h0100
`define B2C_MASK_FAULT_HWC   16'hdf71
`define B2C_MASK_ON_CFG      16'he37f

// Field positions in the fault and hardware-control register
`define B2C_UV_ACT_LSB       14
`define B2C_HWC_SRC_LSB      11
`define B2C_HWC_VPICK_BIT    10
`define B2C_HWC_MODE_LSB     8
`define B2C_HC_THR_LSB       4
`define B2C_HC_EN_BIT        0

// Field positions in the on-configuration register
`define B2C_SLOT_LSB         13
`define B2C_ON_MODE_LSB      8
`define B2C_VSEL_NVM_LSB     2

// Interrupt status bits
`define B2C_IRQ_UV_BIT       0
`define B2C_IRQ_HC_BIT       1

// Voltage code limits and current step
`define B2C_VSEL_FLOOR       7'h08
`define B2C_VSEL_CEIL        7'h68
`define B2C_VSEL_MAX_4MHZ    7'h48
`define B2C_HC_STEP_MA       12'h0fa

`endif

// [logic/b2c_pkg.sv]
`default_nettype none

package b2c_pkg;

    typedef enum logic [1:0] {
        B2C_MODE_FCCM = 2'h0,
        B2C_MODE_AUTO = 2'h1,
        B2C_MODE_LDO  = 2'h2,
        B2C_MODE_HYST = 2'h3
    } b2c_mode_e;

    // In the hardware-control mode field code 01 means disabled
    localparam logic [1:0] B2C_HWC_MODE_OFF = 2'h1;

    typedef enum logic [1:0] {
        B2C_UV_IGNORE   = 2'h0,
        B2C_UV_SHUTDOWN = 2'h1,
        B2C_UV_RESET    = 2'h2,
        B2C_UV_RESERVED = 2'h3
    } b2c_uv_act_e;

    typedef enum logic [1:0] {
        B2C_HWSRC_NONE = 2'h0,
        B2C_HWSRC_IN1  = 2'h1,
        B2C_HWSRC_IN2  = 2'h2,
        B2C_HWSRC_ANY  = 2'h3
    } b2c_hwsrc_e;

    typedef enum logic [1:0] {
        B2C_ST_OFF     = 2'h0,
        B2C_ST_ON      = 2'h1,
        B2C_ST_TRIPPED = 2'h3
    } b2c_state_e;

endpackage

`default_nettype wire

// [logic/b2c_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module b2c_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_async,
    output var  logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            meta_reg <= '0;
            o_sync   <= '0;
        end else begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end

endmodule // b2c_sync

`default_nettype wire
